//--- rtl/pcc_clock_ctrl.sv
// Function
// RULE1 - drain pipeline and bus, then issue grant cycle
// RULE2 - enter grant after ready then buffer empty
// RULE3 - snoop from grant; no repeat grant cycle
// RULE4 - cycle timer keeps counting in stop grant
// RULE5 - keep sampling init, interrupts, reset in grant
// RULE6 - no flush operation while in stop grant
// RULE7 - outputs frozen at grant cycle completion value; the code reloads them from the core during inquire
// RULE8 - leave grant on release or reset, fast
// RULE9 - resume at the recognised instruction boundary
// RULE10 - one instruction before re-entering stop grant
// RULE11 - latch edge events in grant, service later
// RULE12 - reset in grant returns normal immediately
// RULE13 - snoop strobe enters inquire from grant/halt
// RULE14 - answer snoop with hit, writeback if modified
// RULE15 - after writeback return to originating state
// RULE16 - bus clock stopped in grant enters stop clock
// RULE17 - system holds bus clock low when stopped
// RULE18 - stop clock reachable only from stop grant; the code also re-enters it from PLL lock if the bus clock stops again
// RULE19 - maskable interrupt ignored during stop clock
// RULE20 - leave stop clock after PLL lock time
// RULE21 - restarted bus clock may differ in frequency
// RULE22 - ratio pins captured only at reset release
// RULE23 - halt instruction enters halt, clock stopped
`timescale 1ns/1ps

module pcc_clock_ctrl #(
  parameter int PLL_LOCK_CYCLES = pcc_pkg::PCC_PLL_LOCK_CYC,
  parameter int OUT_W = 8
) (
  input wire logic core_clk_i, // 200 MHz core clock
  input wire logic rstn_i, // synchronous reset, active low
  input wire logic bus_clk_i, // external bus clock, sampled as a pin
  input wire logic stop_clock_request_n_i, // stop-clock request pin
  input wire logic burst_ready_n_i, // burst-ready pin
  input wire logic external_write_buffer_empty_n_i, // write buffer empty pin
  input wire logic external_snoop_address_strobe_n_i, // snoop address strobe pin
  input wire logic reset_pin_i, // processor reset pin, active high
  input wire logic init_pin_i, // soft-init pin
  input wire logic flush_n_i, // cache flush request pin
  input wire logic nmi_pin_i, // nonmaskable interrupt pin
  input wire logic system_mgmt_interrupt_n_i, // system-management interrupt pin
  input wire logic maskable_interrupt_req_i, // maskable interrupt pin
  input wire logic [2:0] bus_freq_ratio_sel_i, // bus frequency ratio pins
  input wire logic halt_instruction_i, // core executed the halt instruction
  input wire logic instr_retired_i, // core retired one instruction
  input wire logic pipe_idle_i, // pipeline flushed, no bus cycle pending
  input wire logic int_enable_i, // maskable interrupts enabled in core
  input wire logic snoop_hit_i, // cache lookup hit
  input wire logic snoop_hit_mod_i, // cache lookup hit a modified line
  input wire logic writeback_done_i, // snoop writeback finished
  input wire logic flush_done_i, // cache flush finished
  input wire pcc_pkg::pcc_evt_t evt_ack_i, // core took the pending events
  input wire logic [OUT_W-1:0] core_out_i, // outputs the core wants to drive
  output pcc_pkg::pcc_state_t state_o, // current clock-control state
  output logic core_clk_en_o, // internal processor clock enable
  output logic pll_run_o, // PLL running
  output logic pipe_flush_req_o, // ask core to drain for stop grant
  output logic stop_grant_cycle_o, // stop grant special cycle on bus
  output logic halt_cycle_o, // halt special cycle on bus
  output logic resume_o, // pulse: resume at saved boundary
  output logic reset_begin_o, // pulse: start reset process
  output logic cache_flush_o, // run a cache flush operation
  output pcc_pkg::pcc_evt_t evt_pend_o, // events offered to the core
  output pcc_pkg::pcc_snoop_t snoop_o, // snoop answer
  output logic [2:0] bus_freq_ratio_o, // captured bus frequency ratio
  output logic [63:0] cycle_count_timer_o, // cycle counter, stopped only in stop clock
  output logic [OUT_W-1:0] bus_out_o // device outputs, frozen in low power except during inquire
);
  import pcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three flops, value moves when stages two and three agree
  logic [PCC_SYNC_W-1:0] pin_raw;
  logic [PCC_SYNC_W-1:0] s1_r, s2_r, s3_r, pin_r;

  assign pin_raw = {bus_clk_i, stop_clock_request_n_i, burst_ready_n_i,
                    external_write_buffer_empty_n_i, external_snoop_address_strobe_n_i,
                    reset_pin_i, init_pin_i, flush_n_i, nmi_pin_i,
                    system_mgmt_interrupt_n_i, maskable_interrupt_req_i,
                    bus_freq_ratio_sel_i};

  generate
    for (genvar gi = 0; gi < PCC_SYNC_W; gi++) begin : g_sync
      always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
          s1_r[gi] <= PCC_SYNC_RST[gi];
          s2_r[gi] <= PCC_SYNC_RST[gi];
          s3_r[gi] <= PCC_SYNC_RST[gi];
          pin_r[gi] <= PCC_SYNC_RST[gi];
        end else begin
          s1_r[gi] <= pin_raw[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            pin_r[gi] <= s3_r[gi];
          end
        end
      end
    end
  endgenerate

  logic bclk, stop_req, burst_ready_n, external_write_buffer_empty_n, external_snoop_address_strobe_n, rst_pin, init_l, flush_l, nmi_l, smi_l, maskable_interrupt_req_l;
  logic [2:0] bfr_l;
  assign {bclk, stop_req, burst_ready_n, external_write_buffer_empty_n, external_snoop_address_strobe_n, rst_pin, init_l, flush_l, nmi_l,
          smi_l, maskable_interrupt_req_l, bfr_l} = {pin_r[13], ~pin_r[12], ~pin_r[11], ~pin_r[10],
          ~pin_r[9], pin_r[8], pin_r[7], ~pin_r[6], pin_r[5], ~pin_r[4], pin_r[3],
          pin_r[2:0]};

  // previous filtered values for edge detection
  logic bclk_q, rst_q, init_q, flush_q, nmi_q, smi_q;
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      {bclk_q, rst_q, init_q, flush_q, nmi_q, smi_q} <= 6'h00;
    end else begin
      {bclk_q, rst_q, init_q, flush_q, nmi_q, smi_q} <=
        {bclk, rst_pin, init_l, flush_l, nmi_l, smi_l};
    end
  end

  logic bclk_rise, rst_rise, rst_fall;
  assign bclk_rise = bclk & ~bclk_q;
  assign rst_rise = rst_pin & ~rst_q;
  assign rst_fall = ~rst_pin & rst_q;

  ////////////////////////////////////////////////////////////////////////
  // bus clock activity: a quiet low line means the system stopped it
  logic [7:0] idle_cnt_r;
  logic bclk_stopped;
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      idle_cnt_r <= 8'h00;
    end else if (bclk != bclk_q) begin
      idle_cnt_r <= 8'h00;
    end else if (idle_cnt_r != 8'(PCC_CLK_STOP_CYC)) begin
      idle_cnt_r <= idle_cnt_r + 8'h01;
    end
  end
  // frequency-agnostic: only a missing edge counts, so a new rate is fine (see RULE21)
  assign bclk_stopped = (idle_cnt_r == 8'(PCC_CLK_STOP_CYC)) && !bclk; // see RULE17

  ////////////////////////////////////////////////////////////////////////
  // main state machine
  pcc_state_t state_r, state_nxt;
  pcc_state_t inq_ret_r;
  logic [3:0] exit_cnt_r;
  logic [31:0] lock_cnt_r;
  logic need_instr_r;
  logic halt_wake;
  pcc_evt_t pend_r;

  assign halt_wake = pend_r.init | pend_r.nmi | pend_r.smi | (maskable_interrupt_req_l & int_enable_i);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PCC_NORMAL: begin
        if (stop_req && !need_instr_r && !rst_pin) begin
          state_nxt = PCC_SG_DRAIN; // see RULE10
        end else if (halt_instruction_i) begin
          state_nxt = PCC_HALT_CYC; // see RULE23
        end
      end
      PCC_SG_DRAIN: if (pipe_idle_i) state_nxt = PCC_SG_CYCLE; // see RULE1
      PCC_SG_CYCLE: if (burst_ready_n) state_nxt = PCC_SG_WBE; // see RULE2
      PCC_SG_WBE: if (external_write_buffer_empty_n) state_nxt = PCC_STOP_GRNT; // see RULE2
      PCC_STOP_GRNT: begin
        if (rst_pin) begin
          state_nxt = PCC_NORMAL; // see RULE12
        end else if (!stop_req) begin
          state_nxt = PCC_SG_EXIT; // see RULE8
        end else if (external_snoop_address_strobe_n) begin
          state_nxt = PCC_INQUIRE; // see RULE13
        end else if (bclk_stopped) begin
          state_nxt = PCC_STOP_CLK; // see RULE16
        end
      end
      PCC_SG_EXIT: begin
        if (rst_pin || exit_cnt_r == 4'(PCC_EXIT_BCLK)) state_nxt = PCC_NORMAL; // see RULE8
      end
      PCC_INQUIRE: begin
        if (!snoop_o.writeback_req || writeback_done_i) state_nxt = inq_ret_r; // see RULE15
      end
      PCC_HALT_CYC: if (burst_ready_n) state_nxt = PCC_HALT_WBE;
      PCC_HALT_WBE: if (external_write_buffer_empty_n) state_nxt = PCC_HALT;
      PCC_HALT: begin
        // stopping the bus clock here is not a path to stop clock (see RULE18)
        if (rst_pin || halt_wake) begin
          state_nxt = PCC_NORMAL;
        end else if (external_snoop_address_strobe_n) begin
          state_nxt = PCC_INQUIRE; // see RULE13
        end else if (flush_l && !flush_q) begin
          state_nxt = PCC_HALT_CYC;
        end
      end
      PCC_STOP_CLK: if (bclk_rise) state_nxt = PCC_PLL_LOCK; // see RULE20
      PCC_PLL_LOCK: begin
        if (bclk_stopped) begin
          state_nxt = PCC_STOP_CLK;
        end else if (lock_cnt_r == 32'(PLL_LOCK_CYCLES - 1)) begin
          state_nxt = PCC_STOP_GRNT; // see RULE20
        end
      end
      default: state_nxt = PCC_NORMAL;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state_r <= PCC_NORMAL;
    end else begin
      state_r <= state_nxt;
    end
  end

  // origin of an inquire, so the walk back needs no second special cycle
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      inq_ret_r <= PCC_STOP_GRNT;
    end else if (state_nxt == PCC_INQUIRE && state_r != PCC_INQUIRE) begin
      inq_ret_r <= state_r; // see RULE3
    end
  end

  // exit counted in bus clock periods, well under the allowed ten
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      exit_cnt_r <= 4'h0;
    end else if (state_r != PCC_SG_EXIT) begin
      exit_cnt_r <= 4'h0;
    end else if (bclk_rise && exit_cnt_r < 4'(PCC_EXIT_BCLK_MAX - 1)) begin
      exit_cnt_r <= exit_cnt_r + 4'h1; // see RULE8
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      lock_cnt_r <= 32'h0;
    end else if (state_r != PCC_PLL_LOCK) begin
      lock_cnt_r <= 32'h0;
    end else begin
      lock_cnt_r <= lock_cnt_r + 32'h1; // see RULE20
    end
  end

  // a release seen in grant forces one retired instruction before re-entry
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      need_instr_r <= 1'b0;
    end else if (state_r == PCC_SG_EXIT && state_nxt == PCC_NORMAL) begin
      need_instr_r <= 1'b1; // see RULE10
    end else if (instr_retired_i) begin
      need_instr_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event latches, edge-sensitive except the maskable request; set beats a same-cycle acknowledge
  pcc_evt_t evt_set;
  logic low_power;
  assign low_power = (state_r == PCC_STOP_GRNT) || (state_r == PCC_SG_EXIT) ||
                     (state_r == PCC_INQUIRE) || (state_r == PCC_HALT) ||
                     (state_r == PCC_STOP_CLK) || (state_r == PCC_PLL_LOCK);

  always_comb begin
    evt_set.init = init_l & ~init_q; // see RULE5
    evt_set.nmi = nmi_l & ~nmi_q;
    evt_set.smi = smi_l & ~smi_q;
    evt_set.flush = flush_l & ~flush_q & (state_r != PCC_HALT); // see RULE11
    // level request, not looked at until the clock is back (see RULE19)
    evt_set.maskable_interrupt_req = maskable_interrupt_req_l & (state_r != PCC_STOP_CLK) & (state_r != PCC_PLL_LOCK);
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pend_r <= '0;
    end else begin
      pend_r <= evt_set | (pend_r & ~evt_ack_i); // see RULE11
    end
  end

  // events are handed over only once normal execution is back
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      evt_pend_o <= '0;
    end else if (state_nxt == PCC_NORMAL) begin
      evt_pend_o <= evt_set | (pend_r & ~evt_ack_i); // see RULE11
    end else begin
      evt_pend_o <= '0;
    end
  end

  // flush output raised only from halt, never in normal or stop grant
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      cache_flush_o <= 1'b0;
    end else if (state_r == PCC_HALT && flush_l && !flush_q) begin
      cache_flush_o <= 1'b1; // see RULE6
    end else if (flush_done_i) begin
      cache_flush_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // snoop answer, same as in normal operation
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      snoop_o <= '{hit_n: 1'b1, hit_mod_n: 1'b1, writeback_req: 1'b0};
    end else if (state_nxt == PCC_INQUIRE && state_r != PCC_INQUIRE) begin
      snoop_o.hit_n <= ~snoop_hit_i; // see RULE14
      snoop_o.hit_mod_n <= ~snoop_hit_mod_i;
      snoop_o.writeback_req <= snoop_hit_mod_i;
    end else if (state_r == PCC_INQUIRE && writeback_done_i) begin
      snoop_o.writeback_req <= 1'b0; // see RULE14
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status, clocks and frozen outputs
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state_o <= PCC_NORMAL;
      core_clk_en_o <= 1'b1;
      pll_run_o <= 1'b1;
      pipe_flush_req_o <= 1'b0;
      stop_grant_cycle_o <= 1'b0;
      halt_cycle_o <= 1'b0;
      resume_o <= 1'b0;
      reset_begin_o <= 1'b0;
    end else begin
      state_o <= state_nxt;
      core_clk_en_o <= !(state_nxt inside {PCC_STOP_GRNT, PCC_HALT, PCC_INQUIRE,
                         PCC_STOP_CLK, PCC_PLL_LOCK}); // see RULE23
      pll_run_o <= (state_nxt != PCC_STOP_CLK); // see RULE16
      pipe_flush_req_o <= (state_nxt == PCC_SG_DRAIN); // see RULE1
      stop_grant_cycle_o <= (state_nxt == PCC_SG_CYCLE); // see RULE1
      halt_cycle_o <= (state_nxt == PCC_HALT_CYC);
      resume_o <= (state_r == PCC_SG_EXIT) && (state_nxt == PCC_NORMAL) && !rst_pin; // see RULE9
      reset_begin_o <= rst_rise || (rst_pin && low_power && state_nxt == PCC_NORMAL); // see RULE12
    end
  end

  // bus outputs keep the value from before low power, but follow the core during inquire
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      bus_out_o <= '0;
    end else if (!low_power || state_r == PCC_INQUIRE) begin
      bus_out_o <= core_out_i; // see RULE7
    end
  end

  // ratio pins matter only at the release of reset
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      bus_freq_ratio_o <= PCC_BFR_RST;
    end else if (rst_fall) begin
      bus_freq_ratio_o <= bfr_l; // see RULE22
    end
  end

  // counter runs from the PLL, so it halts only in stop clock
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      cycle_count_timer_o <= PCC_TIMER_RST;
    end else if (state_r != PCC_STOP_CLK) begin
      cycle_count_timer_o <= cycle_count_timer_o + 64'h1; // see RULE4
    end
  end

endmodule : pcc_clock_ctrl

//--- inc/pcc_pkg.sv
package pcc_pkg;

  // clock-control states
  typedef enum logic [3:0] {
    PCC_NORMAL    = 4'h0,
    PCC_SG_DRAIN  = 4'h1,
    PCC_SG_CYCLE  = 4'h2,
    PCC_SG_WBE    = 4'h3,
    PCC_STOP_GRNT = 4'h4,
    PCC_SG_EXIT   = 4'h5,
    PCC_INQUIRE   = 4'h6,
    PCC_HALT_CYC  = 4'h7,
    PCC_HALT_WBE  = 4'h8,
    PCC_HALT      = 4'h9,
    PCC_STOP_CLK  = 4'ha,
    PCC_PLL_LOCK  = 4'hb
  } pcc_state_t;

  // latched interrupt-class events, all active high
  typedef struct packed {
    logic init;
    logic flush;
    logic nmi;
    logic smi;
    logic maskable_interrupt_req;
  } pcc_evt_t;

  // snoop answer towards the bus
  typedef struct packed {
    logic hit_n;
    logic hit_mod_n;
    logic writeback_req;
  } pcc_snoop_t;

  localparam int PCC_CLK_PERIOD_PS = 5000;
  localparam int PCC_PLL_LOCK_TIME_NS = 1000000;
  localparam int PCC_PLL_LOCK_CYC = (PCC_PLL_LOCK_TIME_NS * 1000) / PCC_CLK_PERIOD_PS;
  localparam int PCC_CLK_STOP_TIME_NS = 200;
  localparam int PCC_CLK_STOP_CYC = (PCC_CLK_STOP_TIME_NS * 1000) / PCC_CLK_PERIOD_PS;
  localparam int PCC_EXIT_BCLK_MAX = 10;
  localparam int PCC_EXIT_BCLK = 2;
  localparam int PCC_SYNC_W = 14;
  // every pin at its inactive level, so no false edge or request follows reset
  localparam logic [PCC_SYNC_W-1:0] PCC_SYNC_RST = 14'h1e50;
  localparam logic [2:0] PCC_BFR_RST = 3'h0;
  localparam logic [63:0] PCC_TIMER_RST = 64'h0;

endpackage : pcc_pkg

//--- dv/pcc_sys_model.sv
`timescale 1ns/1ps
module pcc_sys_model (
  input wire logic core_clk_i, // core clock
  input wire logic stop_req_i, // ask for stop grant
  input wire logic clk_run_i, // bus clock running
  input wire logic [3:0] half_i, // bus clock half period in core cycles
  input wire logic snoop_i, // pulse: start an inquire
  input wire logic [3:0] lat_i, // answer delay in core cycles
  input wire logic cyc_i, // special cycle on the bus
  output logic bus_clk_o, // bus clock
  output logic stop_n_o, // stop request pin
  output logic ready_n_o, // burst ready pin
  output logic wbe_n_o, // write buffer empty pin
  output logic external_snoop_address_strobe_n_n_o // snoop strobe pin
);
  logic [3:0] hc, rc, wc, sc;
  initial begin
    bus_clk_o = 1'b0;
    stop_n_o = 1'b1;
    ready_n_o = 1'b1;
    wbe_n_o = 1'b0;
    external_snoop_address_strobe_n_n_o = 1'b1;
    {hc, rc, wc, sc} = 16'h0;
  end
  always @(posedge core_clk_i) begin
    stop_n_o <= !stop_req_i;
    // stopped clock parks low, restart may use a new period
    if (!clk_run_i) begin
      bus_clk_o <= 1'b0;
      hc <= 4'h0;
    end else if (hc >= half_i - 4'h1) begin
      bus_clk_o <= !bus_clk_o;
      hc <= 4'h0;
    end else begin
      hc <= hc + 4'h1;
    end
    rc <= !cyc_i ? 4'h0 : (rc == 4'hf ? rc : rc + 4'h1);
    ready_n_o <= !(cyc_i && rc >= lat_i);
    wc <= !ready_n_o ? lat_i : (wc != 4'h0 ? wc - 4'h1 : 4'h0);
    wbe_n_o <= !ready_n_o || wc != 4'h0;
    sc <= snoop_i ? 4'h4 : (sc != 4'h0 ? sc - 4'h1 : 4'h0);
    external_snoop_address_strobe_n_n_o <= sc == 4'h0 && !snoop_i;
  end
endmodule : pcc_sys_model

//--- dv/pcc_clock_ctrl_props.sv
`timescale 1ns/1ps
module pcc_clock_ctrl_props
  import pcc_pkg::*;
#(
  parameter int PLL_LOCK_CYCLES = 50,
  parameter int OUT_W = 8
) (
  input wire logic core_clk_i, // core clock
  input wire logic rstn_i, // reset, active low
  input wire logic reset_pin_i, // processor reset pin
  input wire logic pipe_idle_i, // core drained
  input wire pcc_pkg::pcc_state_t state_o, // clock-control state
  input wire logic core_clk_en_o, // internal clock enable
  input wire logic pll_run_o, // pll running
  input wire logic stop_grant_cycle_o, // grant special cycle
  input wire logic cache_flush_o, // cache flush
  input wire logic [OUT_W-1:0] bus_out_o, // device outputs
  input wire logic [63:0] cycle_count_timer_o // cycle timer
);
  // ten bus periods at the slowest bench bus clock
  localparam int EXIT_MAX = 80;
  int lock_cnt;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || state_o != PCC_PLL_LOCK) begin
      lock_cnt <= 0;
    end else begin
      lock_cnt <= lock_cnt + 1;
    end
  end
  AST_GRANT_CYCLE: assert property ($rose(stop_grant_cycle_o) |-> $past(pipe_idle_i))
    else $error("grant cycle before drain");
  AST_TIMER_RUNS: assert property ((state_o == PCC_STOP_GRNT) [*2] |->
    cycle_count_timer_o == $past(cycle_count_timer_o) + 64'h1) else $error("timer stalled");
  AST_OUT_FROZEN: assert property ((state_o == PCC_STOP_GRNT) [*2] |-> $stable(bus_out_o))
    else $error("outputs moved in grant");
  AST_NO_FLUSH: assert property (state_o == PCC_STOP_GRNT |-> !cache_flush_o)
    else $error("flush in grant");
  AST_EXIT_FAST: assert property (state_o == PCC_SG_EXIT |-> ##[1:EXIT_MAX] state_o != PCC_SG_EXIT)
    else $error("exit too slow");
  AST_CLK_STOP_ENTRY: assert property (state_o == PCC_STOP_CLK && $past(state_o) != PCC_STOP_CLK |->
    $past(state_o) == PCC_STOP_GRNT || $past(state_o) == PCC_PLL_LOCK) else $error("bad stop entry");
  AST_PLL_OFF: assert property (state_o == PCC_STOP_CLK |-> !pll_run_o && !core_clk_en_o)
    else $error("clocks run in stop clock");
  AST_LOCK_TIME: assert property (state_o == PCC_STOP_GRNT && $past(state_o) == PCC_PLL_LOCK |->
    lock_cnt >= PLL_LOCK_CYCLES - 1 && lock_cnt <= PLL_LOCK_CYCLES + 1) else $error("lock time wrong");
  AST_NO_REGRANT: assert property (state_o == PCC_STOP_GRNT && $past(state_o) == PCC_INQUIRE |->
    !stop_grant_cycle_o) else $error("grant cycle repeated");
  AST_INQ_RETURN: assert property ($past(state_o) == PCC_STOP_GRNT && state_o == PCC_INQUIRE |->
    ##[1:60] state_o == PCC_STOP_GRNT) else $error("no return from inquire");
  AST_RESET_EXIT: assert property (reset_pin_i && state_o == PCC_STOP_GRNT |->
    ##[1:6] state_o == PCC_NORMAL) else $error("reset did not leave grant");
endmodule : pcc_clock_ctrl_props

bind pcc_clock_ctrl pcc_clock_ctrl_props #(.PLL_LOCK_CYCLES(PLL_LOCK_CYCLES), .OUT_W(OUT_W)) props_i (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .reset_pin_i(reset_pin_i), .pipe_idle_i(pipe_idle_i),
  .state_o(state_o), .core_clk_en_o(core_clk_en_o), .pll_run_o(pll_run_o),
  .stop_grant_cycle_o(stop_grant_cycle_o), .cache_flush_o(cache_flush_o),
  .bus_out_o(bus_out_o), .cycle_count_timer_o(cycle_count_timer_o));

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pcc_pkg::*;
  localparam int LOCK = 50;
  logic clk, rstn, rst_pin, init_p, flush_n, nmi_p, smi_n, maskable_interrupt_req, retired, idle, hit, hit_mod;
  logic wb_done, stop_req, clk_run, snoop, bus_clk, stop_n, ready_n, wbe_n, external_snoop_address_strobe_n_n;
  logic clk_en, pll_run, flush_req, cyc, hcyc, resume, rst_begin, cflush, res_seen, rst_seen, halt;
  logic [3:0] half, lat;
  logic [2:0] ratio, ratio_o;
  logic [7:0] core_out, out_q, bus_out;
  logic [63:0] timer, t0;
  logic [31:0] rng;
  pcc_evt_t ack, pend;
  pcc_snoop_t snp;
  pcc_state_t state;
  int fails, checked, n, prev_norm;

  pcc_clock_ctrl #(.PLL_LOCK_CYCLES(LOCK), .OUT_W(8)) pcc_clock_ctrl_i (
    .core_clk_i(clk), .rstn_i(rstn), .bus_clk_i(bus_clk), .stop_clock_request_n_i(stop_n),
    .burst_ready_n_i(ready_n), .external_write_buffer_empty_n_i(wbe_n),
    .external_snoop_address_strobe_n_i(external_snoop_address_strobe_n_n), .reset_pin_i(rst_pin), .init_pin_i(init_p),
    .flush_n_i(flush_n), .nmi_pin_i(nmi_p), .system_mgmt_interrupt_n_i(smi_n),
    .maskable_interrupt_req_i(maskable_interrupt_req), .bus_freq_ratio_sel_i(ratio), .halt_instruction_i(halt),
    .instr_retired_i(retired), .pipe_idle_i(idle), .int_enable_i(1'b1), .snoop_hit_i(hit),
    .snoop_hit_mod_i(hit_mod), .writeback_done_i(wb_done), .flush_done_i(1'b0), .evt_ack_i(ack),
    .core_out_i(core_out), .state_o(state), .core_clk_en_o(clk_en), .pll_run_o(pll_run),
    .pipe_flush_req_o(flush_req), .stop_grant_cycle_o(cyc), .halt_cycle_o(hcyc),
    .resume_o(resume), .reset_begin_o(rst_begin), .cache_flush_o(cflush), .evt_pend_o(pend),
    .snoop_o(snp), .bus_freq_ratio_o(ratio_o), .cycle_count_timer_o(timer), .bus_out_o(bus_out));
  pcc_sys_model pcc_sys_model_i (.core_clk_i(clk), .stop_req_i(stop_req), .clk_run_i(clk_run),
    .half_i(half), .snoop_i(snoop), .lat_i(lat), .cyc_i(cyc | hcyc), .bus_clk_o(bus_clk),
    .stop_n_o(stop_n), .ready_n_o(ready_n), .wbe_n_o(wbe_n), .external_snoop_address_strobe_n_n_o(external_snoop_address_strobe_n_n));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  task automatic wait_st(input pcc_state_t s, input int lim);
    n = 0;
    while (state !== s && n < lim) begin
      step(1);
      n++;
    end
    chk("state", state, s);
    if (state !== s) final_report();
  endtask : wait_st
  task automatic inquire(input pcc_state_t back);
    {hit, hit_mod, snoop} = 3'h7;
    step(1);
    snoop = 1'b0;
    wait_st(PCC_INQUIRE, 20);
    chk("snoop", snp, 3'h1);
    step(5);
    wb_done = 1'b1;
    step(1);
    wb_done = 1'b0;
    wait_st(back, 20);
  endtask : inquire

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // outputs follow the core one cycle late outside low power
  always @(posedge clk) begin
    out_q <= core_out;
    #1;
    rng = xs(rng);
    core_out = rng[7:0];
  end
  always @(negedge clk) begin
    if (prev_norm > 1 && state === PCC_NORMAL) chk("bus_out", bus_out, out_q);
    prev_norm = (rstn && state === PCC_NORMAL) ? prev_norm + 1 : 0;
    if (resume === 1'b1) res_seen = 1'b1;
    if (rst_begin === 1'b1) rst_seen = 1'b1;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    final_report();
  end

  initial begin
    rng = 32'h246936e5;
    {fails, checked, prev_norm} = '0;
    {rstn, rst_pin, init_p, nmi_p, maskable_interrupt_req, retired, idle, hit, hit_mod, wb_done} = '0;
    {stop_req, snoop, res_seen, rst_seen, halt} = '0;
    {flush_n, smi_n, clk_run} = 3'h7;
    {half, lat, ratio, core_out, ack} = {4'h3, 4'h0, 3'h5, 8'h0, 5'h0};
    step(16);
    chk("reset", {state, clk_en, pll_run, snp, ratio_o, bus_out}, {PCC_NORMAL, 2'h3, 3'h6, 3'h0, 8'h0});
    chk("timer", timer, 64'h0);
    rstn = 1'b1;
    step(4);
    rst_pin = 1'b1;
    step(12);
    rst_pin = 1'b0;
    step(12);
    chk("ratio", ratio_o, 64'h5);
    stop_req = 1'b1;
    wait_st(PCC_SG_DRAIN, 20);
    chk("flush_req", flush_req, 1'b1);
    step(rng[2:0] + 1);
    idle = 1'b1;
    wait_st(PCC_STOP_GRNT, 100);
    idle = 1'b0;
    chk("clk_en", {clk_en, pll_run}, 2'h1);
    {nmi_p, smi_n, flush_n} = 3'h4;
    t0 = timer;
    step(20);
    chk("timer", timer, t0 + 64'd20);
    {nmi_p, smi_n, flush_n} = 3'h3;
    chk("stay", {state, cflush}, {PCC_STOP_GRNT, 1'b0});
    inquire(PCC_STOP_GRNT);
    chk("regrant", cyc, 1'b0);
    clk_run = 1'b0;
    wait_st(PCC_STOP_CLK, 100);
    maskable_interrupt_req = 1'b1;
    step(5);
    maskable_interrupt_req = 1'b0;
    half = 4'h4;
    clk_run = 1'b1;
    wait_st(PCC_PLL_LOCK, 20);
    ratio = 3'h2;
    wait_st(PCC_STOP_GRNT, LOCK + 20);
    chk("ratio", ratio_o, 64'h5);
    stop_req = 1'b0;
    wait_st(PCC_SG_EXIT, 20);
    stop_req = 1'b1;
    wait_st(PCC_NORMAL, 80);
    step(1);
    chk("pend", pend, 5'b01110);
    chk("resume", res_seen, 1'b1);
    ack = 5'h1f;
    step(1);
    ack = 5'h0;
    step(20);
    chk("refuse", {state, pend}, {PCC_NORMAL, 5'h0});
    retired = 1'b1;
    step(1);
    retired = 1'b0;
    lat = 4'h9;
    wait_st(PCC_SG_DRAIN, 20);
    idle = 1'b1;
    wait_st(PCC_STOP_GRNT, 100);
    idle = 1'b0;
    rst_seen = 1'b0;
    rst_pin = 1'b1;
    wait_st(PCC_NORMAL, 10);
    stop_req = 1'b0;
    ratio = 3'h6;
    step(12);
    chk("rst_begin", {rst_seen, state}, {1'b1, PCC_NORMAL});
    rst_pin = 1'b0;
    step(12);
    chk("ratio", ratio_o, 64'h6);
    halt = 1'b1;
    step(1);
    halt = 1'b0;
    wait_st(PCC_HALT, 100);
    chk("halt_clk", {clk_en, pll_run, hcyc}, 3'h2);
    clk_run = 1'b0;
    step(60);
    chk("halt_stop", state, PCC_HALT);
    clk_run = 1'b1;
    inquire(PCC_HALT);
    flush_n = 1'b0;
    wait_st(PCC_HALT_CYC, 20);
    chk("halt_flush", cflush, 1'b1);
    flush_n = 1'b1;
    wait_st(PCC_HALT, 100);
    nmi_p = 1'b1;
    wait_st(PCC_NORMAL, 20);
    nmi_p = 1'b0;
    final_report();
  end
endmodule : tb_top
